// file: lcdd_defs.svh
// Purpose: Constants for the 160-output LCD line driver core
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are APB byte addresses
`ifndef LCDD_DEFS_SVH
`define LCDD_DEFS_SVH

// Register byte offsets
`define LCDD_OFS_STATUS 12'h000
`define LCDD_OFS_CTRL   12'h004
`define LCDD_OFS_LINE0  12'h010
`define LCDD_LINE_WORDS 5

// Status field positions
`define LCDD_ST_SEG     0
`define LCDD_ST_SEL     1
`define LCDD_ST_CHAIN   2
`define LCDD_ST_HOLD    3
`define LCDD_ST_CNT_LO  8

// Control field positions and reset value
`define LCDD_CTRL_BLANK 0
`define LCDD_CTRL_RST   32'h0000_0000

// Two-bit bias level codes on drive_outputs
`define LCDD_LVL_TOP     2'h3
`define LCDD_LVL_HIGHMID 2'h2
`define LCDD_LVL_LOWMID  2'h1
`define LCDD_LVL_BOTTOM  2'h0

`endif

// file: lcdd_pkg.sv
// Purpose: Types for the LCD line driver core
// Assumes: Nothing beyond the defs header
// Notes:   One-hot load sequencer states
package lcdd_pkg;

    typedef enum logic [2:0] {
        SEG_WAIT = 3'b001,
        SEG_LOAD = 3'b010,
        SEG_DONE = 3'b100
    } lcdd_seg_state_e;

    typedef logic [1:0] lcdd_level_t;

endpackage

// file: lcdd_line_driver.sv
// Purpose: Digital core of a 160-output segment/common LCD driver
// Assumes: All non-APB pins asynchronous to pclk; pclk far faster than link
// Notes:   Bias levels leave as 2-bit codes per output
`timescale 1ns/1ps
`include "lcdd_defs.svh"

module lcdd_line_driver
    import lcdd_pkg::*;
#(
    parameter int NUM_OUT = 160
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [11:0]        paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               seg_com_select,
    input  wire logic               shift_dir_select,
    input  wire logic               width_mode_select,
    input  wire logic               ac_polarity,
    input  wire logic               display_off_n,
    input  wire logic               data_shift_clock,
    input  wire logic               latch_pulse,
    input  wire logic               data_bit7,
    input  wire logic [6:0]         data_low_bits,
    input  wire logic               chain_enable_in,
    input  wire logic               chain_port_a_in,
    output logic                    chain_port_a_out,
    output logic                    chain_port_a_oe,
    output logic                    chain_port_a_pd,
    input  wire logic               chain_port_b_in,
    output logic                    chain_port_b_out,
    output logic                    chain_port_b_oe,
    output logic                    chain_port_b_pd,
    output logic                    data_bit7_pd,
    output logic                    data_shift_clock_pd,
    output logic [2*NUM_OUT-1:0]    drive_outputs
);

    localparam int HALF = NUM_OUT / 2;

    if (NUM_OUT % 16 != 0 || NUM_OUT > 255 || NUM_OUT < 16) begin : g_bad
        $error("NUM_OUT must be a multiple of 16 in 16..240");
    end

    // Two-flop synchronisers; stage three only for edge detect
    localparam int NSYNC = 18;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic             xck_d;
    logic             lp_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {seg_com_select, shift_dir_select, width_mode_select,
                      ac_polarity, display_off_n, data_shift_clock,
                      latch_pulse, chain_enable_in, chain_port_a_in,
                      chain_port_b_in, data_bit7, data_low_bits};
            sync2 <= sync1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xck_d <= 1'b0;
            lp_d  <= 1'b0;
        end else begin
            xck_d <= sync2[12];
            lp_d  <= sync2[11];
        end
    end

    logic       seg_mode;
    logic       dir_hi;
    logic       wide;
    logic       ac_s;
    logic       pin_on;
    logic       ei_s;
    logic       a_s;
    logic       b_s;
    logic [7:0] din;
    logic       xck_fall;
    logic       lp_fall;
    logic       disp_on;
    logic [31:0] ctrl;

    assign seg_mode = sync2[17];
    assign dir_hi   = sync2[16];
    assign wide     = sync2[15];
    assign ac_s     = sync2[14];
    assign pin_on   = sync2[13];
    assign ei_s     = sync2[10];
    assign a_s      = sync2[9];
    assign b_s      = sync2[8];
    assign din      = sync2[7:0];
    // Shift clock only counts in segment mode
    assign xck_fall = seg_mode && xck_d && !sync2[12];
    assign lp_fall  = lp_d && !sync2[11];
    // Software blank is an extra display-off source
    assign disp_on  = pin_on && !ctrl[`LCDD_CTRL_BLANK];

    // Segment load sequencer
    lcdd_seg_state_e state;
    logic [7:0]      cnt;
    logic            chain_out;
    logic            take;
    logic            last_take;
    logic [7:0]      last_word;
    logic [NUM_OUT-1:0] data_latch;
    logic [NUM_OUT-1:0] line_q;
    logic            blank_hold;

    assign last_word = wide ? 8'(NUM_OUT / 8 - 1)
                            : 8'(NUM_OUT / 4 - 1);
    assign take = xck_fall && (state == SEG_LOAD ||
                  (state == SEG_WAIT && !ei_s));
    assign last_take = take && cnt == last_word;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SEG_DONE;
            cnt   <= '0;
        end else if (!seg_mode) begin
            state <= SEG_DONE;
            cnt   <= '0;
        end else if (lp_fall) begin
            state <= SEG_WAIT;
            cnt   <= '0;
        end else begin
            unique case (state)
                SEG_WAIT, SEG_LOAD: begin
                    if (last_take) begin
                        state <= SEG_DONE;
                        cnt   <= '0;
                    end else if (take) begin
                        state <= SEG_LOAD;
                        cnt   <= cnt + 8'h01;
                    end
                end
                SEG_DONE: begin
                    cnt <= '0;
                end
                default: begin
                    state <= SEG_DONE;
                end
            endcase
        end
    end

    // Low from the fall that ends loading to the next fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_out <= 1'b1;
        end else if (last_take) begin
            chain_out <= 1'b0;
        end else if (xck_fall || !seg_mode) begin
            chain_out <= 1'b1;
        end
    end

    // Latch index for data bit i of word k
    function automatic logic [7:0] seg_pos(input logic dh,
                                           input logic w8,
                                           input logic [7:0] k,
                                           input int i);
        int w;
        int p;
        w = w8 ? 8 : 4;
        if (dh) begin
            p = w * int'(k) + (w - 1 - i);
        end else begin
            p = NUM_OUT - w * (int'(k) + 1) + i;
        end
        return 8'(p);
    endfunction

    // Data latch keeps loading even while display is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_latch <= '0;
        end else if (take) begin
            for (int i = 0; i < 8; i++) begin
                if (i < 4 || wide) begin
                    data_latch[seg_pos(dir_hi, wide, cnt, i)] <= din[i];
                end
            end
        end
    end

    // Line latch in segment mode, scan shift register in common mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q <= '0;
        end else if (!disp_on) begin
            line_q <= '0;
        end else if (lp_fall) begin
            if (seg_mode) begin
                line_q <= data_latch;
            end else if (!wide) begin
                if (dir_hi) begin
                    line_q <= {line_q[NUM_OUT-2:0], a_s};
                end else begin
                    line_q <= {b_s, line_q[NUM_OUT-1:1]};
                end
            end else if (dir_hi) begin
                line_q <= {line_q[NUM_OUT-2:HALF], din[7],
                           line_q[HALF-2:0], a_s};
            end else begin
                line_q <= {b_s, line_q[NUM_OUT-1:HALF+1],
                           din[7], line_q[HALF-1:1]};
            end
        end
    end

    // Deselect level held until the first latch after display on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_hold <= 1'b1;
        end else if (!disp_on) begin
            blank_hold <= 1'b1;
        end else if (lp_fall) begin
            blank_hold <= 1'b0;
        end
    end

    function automatic lcdd_level_t level_of(input logic sm,
                                             input logic ac,
                                             input logic bt);
        lcdd_level_t l;
        unique case ({ac, bt})
            2'b00:   l = `LCDD_LVL_LOWMID;
            2'b01:   l = sm ? `LCDD_LVL_BOTTOM : `LCDD_LVL_TOP;
            2'b10:   l = `LCDD_LVL_HIGHMID;
            default: l = sm ? `LCDD_LVL_TOP : `LCDD_LVL_BOTTOM;
        endcase
        return l;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_outputs <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (!disp_on) begin
                    drive_outputs[2*i +: 2] <= `LCDD_LVL_BOTTOM;
                end else if (blank_hold) begin
                    drive_outputs[2*i +: 2] <= ac_s ? `LCDD_LVL_HIGHMID
                                                    : `LCDD_LVL_LOWMID;
                end else begin
                    drive_outputs[2*i +: 2] <=
                        level_of(seg_mode, ac_s, line_q[i]);
                end
            end
        end
    end

    // Port roles; data_low_bits get no pull, data_bit7 is pulled only in common dual mode
    logic chain_val;
    assign chain_val = seg_mode ? chain_out
                     : (dir_hi ? line_q[NUM_OUT-1] : line_q[0]);
    assign chain_port_a_oe     = !dir_hi;
    assign chain_port_b_oe     = dir_hi;
    assign chain_port_a_out    = chain_val;
    assign chain_port_b_out    = chain_val;
    assign chain_port_a_pd     = !seg_mode && dir_hi;
    assign chain_port_b_pd     = !seg_mode && !dir_hi;
    assign data_bit7_pd        = !seg_mode && wide;
    assign data_shift_clock_pd = !seg_mode;

    // APB slave, zero wait states
    logic       mapped;
    logic [2:0] line_idx;
    assign line_idx = 3'((paddr - `LCDD_OFS_LINE0) >> 2);
    assign mapped = paddr[1:0] == 2'h0 &&
                    (paddr == `LCDD_OFS_STATUS || paddr == `LCDD_OFS_CTRL ||
                     (paddr >= `LCDD_OFS_LINE0 &&
                      paddr < `LCDD_OFS_LINE0 + 12'(4 * `LCDD_LINE_WORDS)));
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `LCDD_CTRL_RST;
        end else if (psel && penable && pwrite &&
                     paddr == `LCDD_OFS_CTRL) begin
            ctrl <= {31'h0, pwdata[`LCDD_CTRL_BLANK]};
        end
    end

    logic [31:0] status;
    always_comb begin
        status = '0;
        status[`LCDD_ST_SEG]   = seg_mode;
        status[`LCDD_ST_SEL]   = state == SEG_LOAD;
        status[`LCDD_ST_CHAIN] = chain_val;
        status[`LCDD_ST_HOLD]  = blank_hold;
        status[`LCDD_ST_CNT_LO +: 8] = cnt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            if (!mapped || pwrite) begin
                prdata <= '0;
            end else if (paddr == `LCDD_OFS_STATUS) begin
                prdata <= status;
            end else if (paddr == `LCDD_OFS_CTRL) begin
                prdata <= ctrl;
            end else begin
                prdata <= line_q[32*line_idx +: 32];
            end
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_chain_drop: assert property (
        last_take |=> !chain_out
            && (dir_hi ? !chain_port_b_out : !chain_port_a_out))
        else $error("chain output did not drop after last word");
    a_chain_return: assert property (
        seg_mode && !chain_out && xck_fall && !last_take
            |=> chain_out)
        else $error("chain output low for more than one shift period");
    a_no_take_done: assert property (
        state == SEG_DONE && !lp_fall |=> $stable(data_latch))
        else $error("data taken while deselected");
    a_off_bottom: assert property (
        !disp_on |=> drive_outputs == '0 && line_q == '0)
        else $error("display off did not force bottom level");
    a_hold_mid: assert property (
        disp_on && blank_hold |=> drive_outputs[1:0] ==
            ($past(ac_s) ? `LCDD_LVL_HIGHMID : `LCDD_LVL_LOWMID))
        else $error("deselect level missing after display on");
    a_seg_capture: assert property (
        seg_mode && disp_on && lp_fall |=> line_q == $past(data_latch))
        else $error("line latch did not capture data latch");
    a_shift_left: assert property (
        !seg_mode && !wide && !dir_hi && disp_on && lp_fall
            |=> line_q[NUM_OUT-2:0] == $past(line_q[NUM_OUT-1:1])
                && line_q[NUM_OUT-1] == $past(b_s))
        else $error("single left shift wrong");
    a_dual_split: assert property (
        !seg_mode && wide && !dir_hi && disp_on && lp_fall
            |=> line_q[HALF-1] == $past(din[7]))
        else $error("dual mode second input wrong");
    a_port_roles: assert property (
        chain_port_a_oe == !dir_hi && chain_port_b_oe == dir_hi
            && chain_port_a_pd == (!seg_mode && !chain_port_a_oe)
            && chain_port_b_pd == (!seg_mode && !chain_port_b_oe))
        else $error("chain port roles inconsistent");

    c_seg4_line: cover property (seg_mode && !wide && last_take);
    c_seg8_line: cover property (seg_mode && wide && last_take);
    c_dual_shift: cover property (!seg_mode && wide && lp_fall);
    c_disp_return: cover property (disp_on && blank_hold ##1 lp_fall);

endmodule

// file: lcdd_ctrl_model.sv
// Purpose: Timing controller model driving the link pins of the core
// Assumes: Own link timebase of 125 ns, unrelated to pclk
// Notes:   Released data lines show the inverse, never the old value
`timescale 1ns/1ps
module lcdd_ctrl_model (
    output logic       data_shift_clock,
    output logic       latch_pulse,
    output logic [7:0] dat,
    output logic       chain_enable_in,
    output logic       far_a,
    output logic       far_b
);
    logic lk;

    initial begin
        lk = 1'b0;
        data_shift_clock = 1'b0;
        latch_pulse = 1'b0;
        dat = 8'h00;
        chain_enable_in = 1'b1;
        far_a = 1'b0;
        far_b = 1'b0;
        forever #62.5 lk = ~lk;
    end

    // One word per shift clock; clock idles low outside frames
    task automatic word(input logic [7:0] d, input logic en_n);
        @(posedge lk);
        data_shift_clock <= 1'b1;
        dat <= d;
        chain_enable_in <= en_n;
        @(negedge lk);
        data_shift_clock <= 1'b0;
    endtask

    // Unused data bits always held at a level, never floating
    task automatic latch(input logic [7:0] d, input logic a, input logic b);
        @(posedge lk);
        latch_pulse <= 1'b1;
        dat <= d;
        far_a <= a;
        far_b <= b;
        @(negedge lk);
        latch_pulse <= 1'b0;
        @(posedge lk);
        dat <= ~d;
        far_a <= ~a;
        far_b <= ~b;
    endtask

    task automatic rel();
        @(posedge lk);
        dat <= ~dat;
        chain_enable_in <= 1'b1;
    endtask
endmodule

// file: lcdd_line_driver_tb.sv
// Purpose: Self-checking bench for the LCD line driver core
// Assumes: Controller model drives the link pins on its own timebase
// Notes:   Expected levels come from the level tables, not the core
`timescale 1ns/1ps
`include "lcdd_defs.svh"
module lcdd_line_driver_tb
    import lcdd_pkg::*;
;
    logic         pclk = 1'b0;
    logic         presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         seg_com_select, shift_dir_select, width_mode_select;
    logic         ac_polarity, display_off_n, far_a, far_b;
    logic         data_shift_clock, latch_pulse, chain_enable_in;
    logic [7:0]   dat;
    logic         chain_port_a_out, chain_port_a_oe, chain_port_a_pd;
    logic         chain_port_b_out, chain_port_b_oe, chain_port_b_pd;
    logic         data_bit7_pd, data_shift_clock_pd;
    logic [319:0] drive_outputs;
    logic [160:1] ex;
    int           err_count = 0;
    int           checked = 0;
    int           cyc = 0;
    wire chain_port_a_in = chain_port_a_oe ? chain_port_a_out : far_a;
    wire chain_port_b_in = chain_port_b_oe ? chain_port_b_out : far_b;

    lcdd_line_driver #(.NUM_OUT(160)) dut_u (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .seg_com_select, .shift_dir_select,
        .width_mode_select, .ac_polarity, .display_off_n,
        .data_shift_clock, .latch_pulse, .data_bit7(dat[7]),
        .data_low_bits(dat[6:0]), .chain_enable_in, .chain_port_a_in,
        .chain_port_a_out, .chain_port_a_oe, .chain_port_a_pd,
        .chain_port_b_in, .chain_port_b_out, .chain_port_b_oe,
        .chain_port_b_pd, .data_bit7_pd, .data_shift_clock_pd,
        .drive_outputs
    );
    lcdd_ctrl_model ctl_u (
        .data_shift_clock, .latch_pulse, .dat, .chain_enable_in,
        .far_a, .far_b
    );

    initial begin
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask

    // Mode 1 display off, 2 deselect hold, 0 normal data
    function automatic lcdd_level_t lvl(input logic b, input int m);
        if (m == 1)
            return `LCDD_LVL_BOTTOM;
        if (m == 2 || !b)
            return ac_polarity ? `LCDD_LVL_HIGHMID : `LCDD_LVL_LOWMID;
        return (ac_polarity ^ !seg_com_select) ? `LCDD_LVL_TOP
                                               : `LCDD_LVL_BOTTOM;
    endfunction

    task automatic check_out(input int m);
        for (int n = 1; n <= 160; n++)
            chk("drive", 32'(drive_outputs[2*n-1 -: 2]),
                32'(lvl(ex[n], m)));
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pins settle through the synchronisers before anything is judged
    task automatic setm(input logic s, d, w, a);
        @(posedge pclk);
        seg_com_select <= s;
        shift_dir_select <= d;
        width_mode_select <= w;
        ac_polarity <= a;
        repeat (8) @(posedge pclk);
    endtask

    task automatic t_apb();
        setm(1, 0, 1, 0);
        apb(1'b0, `LCDD_OFS_STATUS, 32'h0, rd, er);
        chk("status seg", 32'(rd[`LCDD_ST_SEG]), 32'h1);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        chk("unmapped", 32'(er), 32'h1);
        apb(1'b1, `LCDD_OFS_CTRL, 32'h1, rd, er);
        apb(1'b0, `LCDD_OFS_CTRL, 32'h0, rd, er);
        chk("ctrl", rd, 32'h1);
        repeat (4) @(posedge pclk);
        check_out(1);
        apb(1'b1, `LCDD_OFS_CTRL, 32'h0, rd, er);
        $display("apb test done");
    endtask

    task automatic t_seg8();
        logic [7:0] w;
        chk("a oe", 32'(chain_port_a_oe), 32'h1);
        chk("b oe", 32'(chain_port_b_oe), 32'h0);
        ctl_u.latch(8'h00, 1'b0, 1'b0);
        ctl_u.word(8'hff, 1'b1);
        for (int k = 0; k < 20; k++) begin
            w = 8'(k * 29 + 7);
            for (int j = 0; j < 8; j++)
                ex[153 - 8*k + j] = w[j];
            ctl_u.word(w, 1'b0);
        end
        repeat (8) @(posedge pclk);
        chk("chain low", 32'(chain_port_a_out), 32'h0);
        ctl_u.word(8'hff, 1'b0);
        repeat (8) @(posedge pclk);
        chk("chain high", 32'(chain_port_a_out), 32'h1);
        ctl_u.rel();
        ctl_u.latch(8'h00, 1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        check_out(0);
        apb(1'b0, `LCDD_OFS_LINE0, 32'h0, rd, er);
        chk("line0", 32'(rd[0]), 32'(ex[1]));
        $display("seg8 test done");
    endtask

    task automatic t_seg4_off();
        logic [3:0] w;
        setm(1, 1, 0, 1);
        chk("b oe", 32'(chain_port_b_oe), 32'h1);
        chk("a oe", 32'(chain_port_a_oe), 32'h0);
        display_off_n <= 1'b0;
        ctl_u.latch(8'h00, 1'b0, 1'b0);
        for (int k = 0; k < 40; k++) begin
            w = 4'(k * 5 + 3);
            for (int i = 0; i < 4; i++)
                ex[4*k + 4 - i] = w[i];
            ctl_u.word({4'h0, w}, 1'b0);
        end
        repeat (8) @(posedge pclk);
        chk("chain low", 32'(chain_port_b_out), 32'h0);
        ctl_u.rel();
        check_out(1);
        @(posedge pclk);
        display_off_n <= 1'b1;
        repeat (8) @(posedge pclk);
        check_out(2);
        ctl_u.latch(8'h00, 1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        check_out(0);
        $display("seg4 display off test done");
    endtask

    // Display off also empties the shift register, a known start
    task automatic t_com(input logic du, dr);
        setm(0, dr, du, 0);
        display_off_n <= 1'b0;
        repeat (8) @(posedge pclk);
        display_off_n <= 1'b1;
        chk("clk pd", 32'(data_shift_clock_pd), 32'h1);
        chk("d7 pd", 32'(data_bit7_pd), 32'(du));
        chk("a pd", 32'(chain_port_a_pd), 32'(dr));
        chk("b pd", 32'(chain_port_b_pd), 32'(!dr));
        chk("a oe", 32'(chain_port_a_oe), 32'(!dr));
        ex = '0;
        ex[dr ? 1 : 160] = 1'b1;
        if (du)
            ex[dr ? 81 : 80] = 1'b1;
        ctl_u.latch(8'h80, dr, !dr);
        ctl_u.word(8'h00, 1'b0);
        repeat (8) @(posedge pclk);
        check_out(0);
        $display("common test done");
    endtask

    task automatic t_chain();
        for (int k = 0; k < 159; k++)
            ctl_u.latch(8'h00, 1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        ex = '0;
        ex[1] = 1'b1;
        check_out(0);
        chk("chain out", 32'(chain_port_a_out), 32'h1);
        $display("chain test done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Whole run needs about 6500 cycles; the ceiling leaves margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {seg_com_select, shift_dir_select} = 2'b10;
        {width_mode_select, ac_polarity, display_off_n} = 3'b001;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_apb();
        t_seg8();
        t_seg4_off();
        t_com(1'b0, 1'b0);
        t_chain();
        t_com(1'b0, 1'b1);
        t_com(1'b1, 1'b0);
        t_com(1'b1, 1'b1);
        report_and_stop();
    end
endmodule
